/* File: design/serial_ctl_pkg.sv */
// constants shared by the serial control receiver
`default_nettype none

package serial_ctl_pkg;

    localparam int        PHASE_W          = 4;
    localparam int        ADDR_W           = 8;
    localparam int        DATA_W           = 8;
    localparam int        CTL_W            = 9;
    localparam int        NUM_ENABLES      = 24;

    localparam logic [3:0] PHASE_RESET     = 4'h0;
    localparam logic [3:0] PHASE_ADDR_LAST = 4'h7;
    localparam logic [3:0] PHASE_DATA_LAST = 4'hF;

    localparam logic [7:0] ADDR_FIRST      = 8'h10;
    localparam logic [7:0] ADDR_LAST       = 8'h27;
    localparam logic [7:0] MPD_LSB_ADDR    = 8'h26;
    localparam logic [7:0] MPD_MSB_ADDR    = 8'h27;

    localparam logic [7:0] ADDR_RESET      = 8'h00;
    localparam logic [7:0] SHIFT_RESET     = 8'h00;
    localparam logic [8:0] CTL_RESET       = 9'h000;

    localparam int         CTL_MSB_POS     = 8;

    // typical link rate, for reference of bench timing
    localparam int         LINK_BIT_RATE_HZ = 1000000;

    typedef enum logic [1:0] {
        ST_ADDR = 2'b01,
        ST_DATA = 2'b10
    } xfer_state_type;

endpackage : serial_ctl_pkg

`default_nettype wire

/* File: design/link_sampler.sv */
// link-clock side: holds the data line value taken at each serial clock rise
`default_nettype none

module link_sampler (
    input  wire logic i_link_clk,
    input  wire logic i_nrst,
    input  wire logic i_serial_ctl_data_in,
    output logic      o_data_hold
);

    logic data_hold_reg;

    // value stays put from the rise to the next rise, so the fall sees it steady
    always_ff @(posedge i_link_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            data_hold_reg <= 1'b0;
        end else begin
            data_hold_reg <= i_serial_ctl_data_in;
        end
    end

    assign o_data_hold = data_hold_reg;

endmodule : link_sampler

`default_nettype wire

/* File: design/serial_ctl_rx.sv */
// two-wire serial control receiver: address latch, decode, data enables, result readout
`default_nettype none

module serial_ctl_rx
    import serial_ctl_pkg::*;
#(
    parameter logic [7:0] BOX_START_ADDR = 8'h20,
    parameter logic [7:0] BOX_STOP_ADDR  = 8'h22
) (
    input  wire logic                   i_clk,
    input  wire logic                   i_nrst,
    input  wire logic                   i_serial_ctl_clock,
    input  wire logic                   i_serial_ctl_data_in,
    output logic                        o_serial_ctl_data_out,
    output logic                        o_serial_ctl_data_oe_n,
    output logic                        o_addr_latch,
    output logic [ADDR_W-1:0]           o_address,
    output logic [NUM_ENABLES-1:0]      o_data_enable,
    output logic [CTL_W-1:0]            o_ctl_data,
    output logic [1:0]                  o_movie_phase_enable,
    output logic                        o_movie_phase_shift,
    input  wire logic                   i_movie_phase_result_bit
);

    ////////////////////////////////////////////////////////////////////////////
    // decode helpers

    function automatic logic [NUM_ENABLES-1:0] decode_enable(input logic [7:0] addr);
        logic [NUM_ENABLES-1:0] sel;
        sel = '0;
        for (int i = 0; i < NUM_ENABLES; i++) begin
            if (addr == 8'(ADDR_FIRST + i)) begin
                sel[i] = 1'b1;
            end
        end
        return sel;
    endfunction : decode_enable

    function automatic logic is_read_addr(input logic [7:0] addr);
        return (addr == MPD_LSB_ADDR) || (addr == MPD_MSB_ADDR);
    endfunction : is_read_addr

    ////////////////////////////////////////////////////////////////////////////
    // link domain sampler

    logic data_hold;

    link_sampler u_link_sampler (
        .i_link_clk           (i_serial_ctl_clock),
        .i_nrst               (i_nrst),
        .i_serial_ctl_data_in (i_serial_ctl_data_in),
        .o_data_hold          (data_hold)
    );

    ////////////////////////////////////////////////////////////////////////////
    // synchronisers and edge detection

    logic clk_s1_reg;
    logic clk_s2_reg;
    logic clk_s3_reg;
    logic dat_s1_reg;
    logic dat_s2_reg;

    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            clk_s1_reg <= 1'b1;
            clk_s2_reg <= 1'b1;
            clk_s3_reg <= 1'b1;
            dat_s1_reg <= 1'b0;
            dat_s2_reg <= 1'b0;
        end else begin
            clk_s1_reg <= i_serial_ctl_clock;
            clk_s2_reg <= clk_s1_reg;
            clk_s3_reg <= clk_s2_reg;
            dat_s1_reg <= data_hold;
            dat_s2_reg <= dat_s1_reg;
        end
    end

    wire sck_rise = clk_s2_reg & ~clk_s3_reg;
    wire sck_fall = ~clk_s2_reg & clk_s3_reg;

    ////////////////////////////////////////////////////////////////////////////
    // shift register, phase counter, transfer state

    logic [DATA_W-1:0]  shift_reg;
    logic [DATA_W-1:0]  shift_next;
    logic [PHASE_W-1:0] phase_reg;
    logic [PHASE_W-1:0] phase_next;
    xfer_state_type     state_reg;
    xfer_state_type     state_next;

    wire addr_end = sck_fall && (phase_reg == PHASE_ADDR_LAST) && (state_reg == ST_ADDR);
    wire data_end = sck_fall && (phase_reg == PHASE_DATA_LAST) && (state_reg == ST_DATA);

    assign shift_next = sck_fall ? {shift_reg[DATA_W-2:0], dat_s2_reg} : shift_reg;
    assign phase_next = sck_rise ? phase_reg + 4'h1 : phase_reg;

    always_comb begin
        state_next = state_reg;
        case (state_reg)
            ST_ADDR: begin
                if (addr_end) begin
                    state_next = ST_DATA;
                end
            end
            ST_DATA: begin
                if (data_end) begin
                    state_next = ST_ADDR;
                end
            end
            default: begin
                state_next = ST_ADDR;
            end
        endcase
    end

    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            shift_reg <= SHIFT_RESET;
            phase_reg <= PHASE_RESET;
            state_reg <= ST_ADDR;
        end else begin
            shift_reg <= shift_next;
            phase_reg <= phase_next;
            state_reg <= state_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // address latch and two-step decode

    logic                   addr_latch_reg;
    logic [ADDR_W-1:0]      address_reg;
    logic                   in_range_reg;
    logic [NUM_ENABLES-1:0] sel_reg;
    logic                   read_sel_reg;
    logic                   box_sel_reg;
    logic [1:0]             dec_step_reg;
    logic                   dec_done_reg;
    logic                   dec_done_next;

    wire addr_in_range = (address_reg >= ADDR_FIRST) && (address_reg <= ADDR_LAST);
    wire addr_is_box   = (address_reg[7:1] == BOX_START_ADDR[7:1])
                       || (address_reg[7:1] == BOX_STOP_ADDR[7:1]);

    // selects are stale until both decode steps have seen the new address
    assign dec_done_next = addr_end ? 1'b0 : (dec_step_reg[1] ? 1'b1 : dec_done_reg);

    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            addr_latch_reg <= 1'b0;
            address_reg    <= ADDR_RESET;
            in_range_reg   <= 1'b0;
            sel_reg        <= '0;
            read_sel_reg   <= 1'b0;
            box_sel_reg    <= 1'b0;
            dec_step_reg   <= 2'b00;
            dec_done_reg   <= 1'b0;
        end else begin
            addr_latch_reg <= addr_end;
            if (addr_latch_reg) begin
                address_reg <= shift_reg;
            end
            in_range_reg   <= addr_in_range;
            sel_reg        <= in_range_reg ? decode_enable(address_reg) : '0;
            read_sel_reg   <= in_range_reg && is_read_addr(address_reg);
            box_sel_reg    <= in_range_reg && addr_is_box;
            dec_step_reg   <= {dec_step_reg[0], addr_latch_reg};
            dec_done_reg   <= dec_done_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // data enables and control data

    logic                   data_strobe_reg;
    logic [NUM_ENABLES-1:0] data_enable_reg;
    logic [CTL_W-1:0]       ctl_data_reg;
    logic [CTL_W-1:0]       ctl_data_next;

    // box pairs carry the address lsb as ninth bit
    assign ctl_data_next = box_sel_reg ? {address_reg[0], shift_reg}
                                       : {1'b0, shift_reg};

    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            data_strobe_reg <= 1'b0;
            data_enable_reg <= '0;
            ctl_data_reg    <= CTL_RESET;
        end else begin
            data_strobe_reg <= data_end;
            data_enable_reg <= (data_strobe_reg && !read_sel_reg) ? sel_reg : '0;
            if (data_strobe_reg) begin
                ctl_data_reg <= ctl_data_next;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // result readout

    logic [1:0] mpd_en_reg;
    logic       mpd_shift_reg;
    logic       sda_out_reg;
    logic       sda_oe_n_reg;

    wire        read_active = (state_reg == ST_DATA) && dec_done_reg && read_sel_reg;

    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            mpd_en_reg    <= 2'b00;
            mpd_shift_reg <= 1'b0;
            sda_out_reg   <= 1'b1;
            sda_oe_n_reg  <= 1'b1;
        end else begin
            mpd_en_reg    <= read_active ? sel_reg[NUM_ENABLES-1:NUM_ENABLES-2] : 2'b00;
            mpd_shift_reg <= sck_fall && (state_reg == ST_DATA);
            sda_out_reg   <= i_movie_phase_result_bit;
            sda_oe_n_reg  <= ~read_active;
        end
    end

    assign o_serial_ctl_data_out  = sda_out_reg;
    assign o_serial_ctl_data_oe_n = sda_oe_n_reg;
    assign o_addr_latch           = addr_latch_reg;
    assign o_address              = address_reg;
    assign o_data_enable          = data_enable_reg;
    assign o_ctl_data             = ctl_data_reg;
    assign o_movie_phase_enable   = mpd_en_reg;
    assign o_movie_phase_shift    = mpd_shift_reg;

    ////////////////////////////////////////////////////////////////////////////
    // checks

    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_nrst);

    a_phase_advance: assert property (
        sck_rise |=> phase_reg == $past(phase_reg) + 4'h1
    ) else $error("phase counter did not advance on rise");

    a_fall_shift: assert property (
        sck_fall |=> shift_reg == {$past(shift_reg[6:0]), $past(dat_s2_reg)}
    ) else $error("data not shifted on fall");

    a_latch_timing: assert property (
        addr_latch_reg |-> $past(sck_fall) && $past(phase_reg) == PHASE_ADDR_LAST
    ) else $error("address strobe outside phase seven fall");

    a_latch_copy: assert property (
        addr_latch_reg |=> address_reg == $past(shift_reg)
    ) else $error("address not copied from shift register");

    a_range_gate: assert property (
        $rose(in_range_reg) |-> ##1 (sel_reg != '0) && !(address_reg < ADDR_FIRST)
    ) else $error("range check and select disagree");

    a_enable_pulse: assert property (
        (data_enable_reg != '0) |-> $past(data_strobe_reg, 1) ##1 (data_enable_reg == '0)
    ) else $error("data enable not a single pulse after sixteenth fall");

    a_box_msb: assert property (
        $rose(ctl_data_reg[CTL_MSB_POS]) |-> $past(box_sel_reg) && $past(address_reg[0])
    ) else $error("ninth data bit set outside box address");

    a_result_shift: assert property (
        mpd_shift_reg |-> $past(sck_fall) && $past(state_reg) == ST_DATA
    ) else $error("result shift outside a data phase fall");

    a_drive_read: assert property (
        !o_serial_ctl_data_oe_n |-> (mpd_en_reg != 2'b00) || $past(read_active)
    ) else $error("data line driven without read address");

    a_decode_settle: assert property (
        $rose(dec_done_reg) |-> $past(addr_latch_reg, 3)
    ) else $error("decode done not three cycles after address strobe");

    a_sel_onehot: assert property (
        $onehot0(sel_reg)
    ) else $error("more than one address selected");

    a_sel_range: assert property (
        dec_done_reg && (sel_reg != '0) |-> (address_reg >= ADDR_FIRST) && (address_reg <= ADDR_LAST)
    ) else $error("select given for address outside range");

    a_latch_pulse: assert property (
        addr_latch_reg |=> !addr_latch_reg
    ) else $error("address strobe longer than one cycle");

    a_latch_state: assert property (
        addr_latch_reg |-> state_reg == ST_DATA
    ) else $error("address strobe without entering data phases");

    a_enable_onehot: assert property (
        $onehot0(data_enable_reg)
    ) else $error("more than one data enable at once");

    a_enable_no_read: assert property (
        data_enable_reg[NUM_ENABLES-1:NUM_ENABLES-2] == 2'b00
    ) else $error("data enable pulse for a read address");

    a_ctl_load: assert property (
        (data_enable_reg != '0) |-> ctl_data_reg[DATA_W-1:0] == $past(shift_reg)
    ) else $error("control data not the received byte");

    a_plain_msb: assert property (
        (data_enable_reg != '0) && !box_sel_reg |-> !ctl_data_reg[CTL_MSB_POS]
    ) else $error("ninth bit set for plain address");

    a_result_hold: assert property (
        read_active |=> (mpd_en_reg != 2'b00) && !o_serial_ctl_data_oe_n
    ) else $error("result enable dropped during read data phase");

    a_result_release: assert property (
        (mpd_en_reg != 2'b00) |-> $past(state_reg) == ST_DATA
    ) else $error("result enable outside data phases");

    a_shift_pulse: assert property (
        mpd_shift_reg |=> !mpd_shift_reg
    ) else $error("result shift longer than one cycle");

    a_state_legal: assert property (
        (state_reg == ST_ADDR) || (state_reg == ST_DATA)
    ) else $error("transfer state not one-hot");

endmodule : serial_ctl_rx

`default_nettype wire

/* File: bench/host_model.sv */
// host side model: drives serial clock and data line from a queue of transfers
`default_nettype none

module host_model (
    input  wire logic       i_line,
    output logic            o_sclk,
    output logic            o_bit,
    output logic            o_drive,
    output logic            o_rd_done,
    output logic [7:0]      o_rd_byte
);
    timeunit 1ns;
    timeprecision 100ps;

    logic        base_clk;
    logic [15:0] xfer_q[$];

    // free-running link base, unrelated in phase to the system clock
    initial begin
        base_clk = 1'b0;
        #7;
        forever #40 base_clk = ~base_clk;
    end

    task automatic wait_base(input int n);
        repeat (n) @(posedge base_clk);
    endtask : wait_base

    ////////////////////////////////////////////////////////////////////////////
    initial begin : run
        logic [15:0] cur;
        logic [15:0] nxt;
        logic [7:0]  rd;
        logic        is_rd;
        o_sclk = 1'b1;
        o_bit = 1'b0;
        o_drive = 1'b1;
        o_rd_done = 1'b0;
        o_rd_byte = 8'h00;
        rd = 8'h00;
        forever begin
            while (xfer_q.size() == 0) wait_base(1);
            cur = xfer_q.pop_front();
            is_rd = (cur[15:9] == 7'h13);
            // halves of six base periods, about one bit per microsecond
            for (int k = 0; k < 16; k++) begin
                wait_base(1);
                o_sclk <= 1'b0;
                if (is_rd && k == 7) o_drive <= 1'b0;
                wait_base(2);
                nxt = (k == 15) ? ((xfer_q.size() != 0) ? xfer_q[0] : 16'h0000) : cur << (k + 1);
                o_drive <= !(is_rd && k >= 7 && k < 15);
                o_bit <= nxt[15];
                wait_base(4);
                o_sclk <= 1'b1;
                wait_base(5);
                if (k >= 7 && k < 15) rd = {rd[6:0], i_line};
            end
            if (is_rd) begin
                o_rd_byte <= rd;
                o_rd_done <= 1'b1;
                wait_base(1);
                o_rd_done <= 1'b0;
            end
        end
    end

endmodule : host_model

`default_nettype wire

/* File: bench/tb_top.sv */
// self-checking bench for the serial control receiver
`default_nettype none

module tb_top
    import serial_ctl_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;

    logic                   clk;
    logic                   rst_n;
    logic                   flt = 1'b0;
    wire logic              line;
    logic                   sclk, host_bit, host_drive, rd_done;
    logic [7:0]             rd_byte;
    logic                   data_out, oe_n, lat, shift;
    logic                   lat_d = 1'b0;
    logic [ADDR_W-1:0]      addr;
    logic [NUM_ENABLES-1:0] en;
    logic [CTL_W-1:0]       ctl;
    logic [1:0]             mpe;
    logic [7:0]             res_sr = 8'h00;
    logic                   mpe_d = 1'b0;
    logic [15:0]            lfsr;
    logic [7:0]             addr_q[$], rd_q[$];
    logic [9:0]             load_q[$];
    logic [32:0]            en_q[$];
    int                     err_count = 0;
    int                     n_tests = 0;
    int                     nlat = 0;
    int                     shift_cnt = 0;

    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end

    // line level: device, then host, else a pattern that changes every cycle
    assign line = !oe_n ? data_out : host_drive ? host_bit : flt;
    always @(posedge clk) flt <= ~flt;

    host_model host_u (.i_line(line), .o_sclk(sclk), .o_bit(host_bit), .o_drive(host_drive),
                       .o_rd_done(rd_done), .o_rd_byte(rd_byte));

    serial_ctl_rx dut_u (.i_clk(clk), .i_nrst(rst_n), .i_serial_ctl_clock(sclk),
        .i_serial_ctl_data_in(line), .o_serial_ctl_data_out(data_out),
        .o_serial_ctl_data_oe_n(oe_n), .o_addr_latch(lat), .o_address(addr),
        .o_data_enable(en), .o_ctl_data(ctl), .o_movie_phase_enable(mpe),
        .o_movie_phase_shift(shift), .i_movie_phase_result_bit(res_sr[7]));

    ////////////////////////////////////////////////////////////////////////////
    function automatic logic [15:0] lfsr_next(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction : lfsr_next

    task automatic check(input logic [32:0] seen, input logic [32:0] exp);
        n_tests++;
        if (seen !== exp) begin
            err_count++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic complete_run();
        $display("checks %0d mismatches %0d", n_tests, err_count);
        if (err_count == 0 && n_tests > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : complete_run

    task automatic send(input logic [7:0] a);
        logic [7:0] d;
        lfsr = lfsr_next(lfsr);
        d = lfsr[7:0];
        host_u.xfer_q.push_back({a, d});
        addr_q.push_back(a);
        if (a >= ADDR_FIRST && a < MPD_LSB_ADDR) begin
            en_q.push_back({(a[7:1] == 7'h10 || a[7:1] == 7'h11) & a[0], d,
                            24'h000001 << (a - ADDR_FIRST)});
        end
        if (a == MPD_LSB_ADDR || a == MPD_MSB_ADDR) begin
            load_q.push_back({a[0], ~a[0], d});
            rd_q.push_back(d);
            send(8'h00);
        end
    endtask : send

    task automatic drain(input string name);
        while (host_u.xfer_q.size() != 0) @(posedge clk);
        repeat (800) @(posedge clk);
        check(33'(addr_q.size() + en_q.size() + rd_q.size()), 33'h0);
        $display("test %s done", name);
    endtask : drain

    ////////////////////////////////////////////////////////////////////////////
    // result circuit: loads on read select, shifts on each pulse
    always @(posedge clk) begin
        mpe_d <= |mpe;
        if (|mpe && !mpe_d) begin
            check(33'(mpe), 33'(load_q[0][9:8]));
            res_sr <= load_q[0][7:0];
            void'(load_q.pop_front());
        end else if (shift) begin
            res_sr <= {res_sr[6:0], 1'b0};
        end
    end

    always @(negedge clk) begin
        if (rst_n) begin
            if (!oe_n) check(33'(host_drive), 33'h0);
            if (!oe_n) check(33'(mpe != 2'b00), 33'h1);
            if (lat_d && nlat > 1) check(33'(addr), 33'(addr_q.pop_front()));
            if (lat) begin
                if (nlat > 0) check(33'(shift_cnt), 33'h8);
                shift_cnt = 0;
                nlat++;
            end else if (shift) begin
                shift_cnt++;
            end
            lat_d = lat;
            if (|en) check({ctl, en}, (en_q.size() != 0) ? en_q.pop_front() : 33'h0);
        end
    end

    always @(posedge rd_done) check(33'(rd_byte), 33'(rd_q.pop_front()));

    initial begin : watchdog
        #1200000;
        err_count++;
        complete_run();
    end

    initial begin : main
        rst_n = 1'b0;
        lfsr = 16'h20FF;
        repeat (8) @(posedge clk);
        rst_n <= 1'b1;
        repeat (4) @(posedge clk);
        // first transfer after reset only brings the sampler into step
        host_u.xfer_q.push_back(16'h0000);
        for (int a = 16'h0F; a <= 16'h28; a++) send(a[7:0]);
        send(8'hFF);
        send(8'h00);
        drain("sweep");
        send(MPD_MSB_ADDR);
        send(MPD_LSB_ADDR);
        drain("reads");
        complete_run();
    end

endmodule : tb_top

`default_nettype wire
